// [hdl/wake_pkg.sv]
package wake_pkg;

    // Radio activity levels
    typedef enum logic [1:0]
    {
        radio_off,
        radio_scan,
        radio_link
    } radio_e;

    // Power modes
    typedef enum logic [2:0]
    {
        mode_all_off,
        mode_uart_only,
        mode_scan_uart_off,
        mode_scan_uart_on,
        mode_link_uart_off,
        mode_link_uart_on
    } power_mode_e;

    // Reference clock selection
    typedef enum logic [1:0]
    {
        refclk_none,
        refclk_main,
        refclk_low_power
    } refclk_e;

    // Wake-up line levels: asserted means driven low
    localparam logic WAKE_ASSERTED = 1'b0;
    localparam logic WAKE_IDLE = 1'b1;

    // Internal pull defaults of the start-up straps
    localparam logic STARTUP_STRAP_DEFAULT = 1'b0;
    localparam logic ENV_STRAP_DEFAULT = 1'b1;

    localparam int HOST_CFG_W = 3;
    localparam logic [HOST_CFG_W-1:0] HOST_CFG_RESET = 3'h0;

endpackage

// [hdl/power_mode_map.sv]
`timescale 1ns/10ps
module power_mode_map
    import wake_pkg::*;
(
    // Activity inputs
    input wire logic uart_on,
    input wire radio_e radio,
    input wire logic lp_clk_allowed,
    // Mode outputs
    output power_mode_e mode,
    output refclk_e refclk
);

    always_comb
    begin
        unique case (radio)
            radio_scan:
            begin
                mode = uart_on ? mode_scan_uart_on : mode_scan_uart_off;
                refclk = (!uart_on && lp_clk_allowed) ? refclk_low_power : refclk_main;
            end
            radio_link:
            begin
                mode = uart_on ? mode_link_uart_on : mode_link_uart_off;
                refclk = refclk_main;
            end
            default:
            begin
                mode = uart_on ? mode_uart_only : mode_all_off;
                refclk = uart_on ? refclk_main : refclk_none;
            end
        endcase
    end

endmodule

// [hdl/uart_transport_wakeup_power.sv]
`timescale 1ns/10ps
// Summary of operation
// - UART transport enabled straight after reset
// - Only host disable command turns transport off
// - Re-enable only through hardware wake-up handshake
// - Six power modes from UART and radio
// - No clock idle; low-power clock when scanning with UART off, if allowed
// - Remote link changes update radio activity
// - Disable: drain, confirm, then UART off
// - Disabled UART wakes on CTS falling edge
// - Check transport enabled before sending anything
// - Pending data while disabled: assert RTS
// - After host RTS: confirm first, then events
// - Host wake-up: power UART, assert RTS
// - Confirm host wake-up with enabled event
// - Power down link controller and radio idle
// - Host config taken from three straps at boot
// - Start-up straps default low, environment high
module uart_transport_wakeup_power
    import wake_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Host command decoder
    input wire logic disable_cmd,
    // Event path
    input wire logic tx_pending,
    input wire logic tx_buf_empty,
    input wire logic confirm_done,
    output logic confirm_req,
    output logic tx_allow,
    // Radio activity requests
    input wire logic scan_req,
    input wire logic host_link_req,
    input wire logic remote_link_up,
    input wire logic remote_link_down,
    input wire logic lp_clk_allowed,
    // Wake-up lines, crossed to the host
    input wire logic cts,
    output logic rts,
    // Power controls
    output logic uart_power,
    output logic link_controller_power,
    output logic radio_power,
    output power_mode_e power_mode,
    output refclk_e refclk_sel,
    // Boot straps
    input wire logic host_cfg_strap_a,
    input wire logic host_cfg_strap_b,
    input wire logic host_cfg_strap_c,
    input wire logic startup_strap_a,
    input wire logic startup_strap_b,
    input wire logic environment_strap,
    input wire logic startup_strap_a_driven,
    input wire logic startup_strap_b_driven,
    input wire logic environment_strap_driven,
    output logic [HOST_CFG_W-1:0] host_cfg,
    output logic startup_opt_a,
    output logic startup_opt_b,
    output logic environment_opt
);

    typedef enum logic [2:0]
    {
        st_on,
        st_drain,
        st_confirm_off,
        st_off,
        st_dev_wake,
        st_confirm_on
    } xport_e;

    xport_e state_ff, nxt_state;
    logic rts_ff, nxt_rts;
    logic cts_prev_ff, nxt_cts_prev;
    logic remote_link_ff, nxt_remote_link;
    logic straps_taken_ff, nxt_straps_taken;
    logic [HOST_CFG_W-1:0] host_cfg_ff, nxt_host_cfg;
    logic opt_a_ff, nxt_opt_a;
    logic opt_b_ff, nxt_opt_b;
    logic env_ff, nxt_env;
    logic uart_on;
    logic cts_fall;
    radio_e radio;

    // Resolves an unconnected strap to its internal pull default
    function automatic logic strap_level(input logic level, input logic driven, input logic dflt);
        strap_level = driven ? level : dflt;
    endfunction

    // Any radio activity needs both the radio and the link controller supplied
    function automatic logic radio_active(input radio_e level);
        radio_active = (level != radio_off);
    endfunction

    assign cts_fall = cts_prev_ff && (cts == WAKE_ASSERTED);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_rts = rts_ff;
        nxt_cts_prev = cts;
        unique case (state_ff)
            st_on:
            begin
                nxt_rts = WAKE_ASSERTED;
                if (disable_cmd)
                begin
                    nxt_state = st_drain;
                end
            end
            st_drain:
            begin
                if (tx_buf_empty)
                begin
                    nxt_state = st_confirm_off;
                end
            end
            st_confirm_off:
            begin
                if (confirm_done)
                begin
                    nxt_state = st_off;
                    nxt_rts = WAKE_IDLE;
                end
            end
            st_off:
            begin
                if (cts_fall)
                begin
                    nxt_state = st_confirm_on;
                    nxt_rts = WAKE_ASSERTED;
                end
                else if (tx_pending)
                begin
                    nxt_state = st_dev_wake;
                    nxt_rts = WAKE_ASSERTED;
                end
            end
            st_dev_wake:
            begin
                if (cts_fall || cts == WAKE_ASSERTED)
                begin
                    nxt_state = st_confirm_on;
                end
            end
            st_confirm_on:
            begin
                if (confirm_done)
                begin
                    nxt_state = st_on;
                end
            end
            // Unused state codes fall back to the enabled transport
            default:
            begin
                nxt_state = st_on;
                nxt_rts = WAKE_ASSERTED;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= st_on;
            rts_ff <= WAKE_ASSERTED;
            cts_prev_ff <= WAKE_ASSERTED;
        end
        else
        begin
            state_ff <= nxt_state;
            rts_ff <= nxt_rts;
            cts_prev_ff <= nxt_cts_prev;
        end
    end

    // Transport usable for the UART hardware
    assign uart_on = (state_ff != st_off) && (state_ff != st_dev_wake);
    assign uart_power = uart_on;
    assign rts = rts_ff;
    assign confirm_req = (state_ff == st_confirm_off) || (state_ff == st_confirm_on);
    assign tx_allow = (state_ff == st_on) || (state_ff == st_drain);

    // Remote link tracking
    always_comb
    begin
        nxt_remote_link = remote_link_ff;
        if (remote_link_up)
        begin
            nxt_remote_link = 1'b1;
        end
        else if (remote_link_down)
        begin
            nxt_remote_link = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            remote_link_ff <= 1'b0;
        end
        else
        begin
            remote_link_ff <= nxt_remote_link;
        end
    end

    always_comb
    begin
        if (remote_link_ff || host_link_req)
        begin
            radio = radio_link;
        end
        else if (scan_req)
        begin
            radio = radio_scan;
        end
        else
        begin
            radio = radio_off;
        end
    end

    assign radio_power = radio_active(radio);
    assign link_controller_power = radio_active(radio);

    power_mode_map u_map
    (
        .uart_on(uart_on),
        .radio(radio),
        .lp_clk_allowed(lp_clk_allowed),
        .mode(power_mode),
        .refclk(refclk_sel)
    );

    // Strap capture on the first edge after reset release
    always_comb
    begin
        nxt_straps_taken = 1'b1;
        nxt_host_cfg = host_cfg_ff;
        nxt_opt_a = opt_a_ff;
        nxt_opt_b = opt_b_ff;
        nxt_env = env_ff;
        if (!straps_taken_ff)
        begin
            nxt_host_cfg = {host_cfg_strap_c, host_cfg_strap_b, host_cfg_strap_a};
            nxt_opt_a = strap_level(startup_strap_a, startup_strap_a_driven, STARTUP_STRAP_DEFAULT);
            nxt_opt_b = strap_level(startup_strap_b, startup_strap_b_driven, STARTUP_STRAP_DEFAULT);
            nxt_env = strap_level(environment_strap, environment_strap_driven, ENV_STRAP_DEFAULT);
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            straps_taken_ff <= 1'b0;
            host_cfg_ff <= HOST_CFG_RESET;
            opt_a_ff <= STARTUP_STRAP_DEFAULT;
            opt_b_ff <= STARTUP_STRAP_DEFAULT;
            env_ff <= ENV_STRAP_DEFAULT;
        end
        else
        begin
            straps_taken_ff <= nxt_straps_taken;
            host_cfg_ff <= nxt_host_cfg;
            opt_a_ff <= nxt_opt_a;
            opt_b_ff <= nxt_opt_b;
            env_ff <= nxt_env;
        end
    end

    assign host_cfg = host_cfg_ff;
    assign startup_opt_a = opt_a_ff;
    assign startup_opt_b = opt_b_ff;
    assign environment_opt = env_ff;

endmodule

// [tb/wake_props.sv]
`timescale 1ns/10ps
module wake_props
    import wake_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Wake-up and event path
    input wire logic cts,
    input wire logic rts,
    input wire logic tx_pending,
    input wire logic confirm_req,
    input wire logic confirm_done,
    input wire logic tx_allow,
    // Power
    input wire logic uart_power,
    input wire logic radio_power,
    input wire logic link_controller_power,
    input wire power_mode_e power_mode,
    input wire refclk_e refclk_sel
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    boot_enabled_a: assert property ($fell(rst) |-> uart_power && tx_allow)
        else $error("uart off after reset");
    mode_uart_a: assert property (power_mode[0] == uart_power)
        else $error("mode and uart disagree");
    idle_clock_a: assert property (power_mode == mode_all_off |-> refclk_sel == refclk_none)
        else $error("clock in idle mode");
    main_clock_a: assert property (power_mode inside {mode_uart_only, mode_scan_uart_on,
        mode_link_uart_off, mode_link_uart_on} |-> refclk_sel == refclk_main)
        else $error("main clock missing");
    radio_gate_a: assert property (radio_power == (power_mode >= mode_scan_uart_off)
        && link_controller_power == radio_power)
        else $error("radio power wrong");
    confirm_off_a: assert property ($fell(uart_power) |-> $past(confirm_req && confirm_done))
        else $error("uart off before confirm");
    silent_off_a: assert property (!uart_power |-> !tx_allow)
        else $error("events while off");
    host_wake_a: assert property (!uart_power && rts == WAKE_IDLE && $past(cts) && !cts
        |=> uart_power && rts == WAKE_ASSERTED && confirm_req)
        else $error("host wake missed");
    dev_wake_a: assert property (!uart_power && rts == WAKE_IDLE && cts && tx_pending
        |=> rts == WAKE_ASSERTED && !uart_power)
        else $error("device wake missed");
    confirm_first_a: assert property ($rose(uart_power) |-> confirm_req && !tx_allow)
        else $error("events before confirm");
endmodule
bind uart_transport_wakeup_power wake_props i_props
(
    .mclk(mclk), .rst(rst), .cts(cts), .rts(rts), .tx_pending(tx_pending), .confirm_req(confirm_req),
    .confirm_done(confirm_done), .tx_allow(tx_allow), .uart_power(uart_power), .radio_power(radio_power),
    .link_controller_power(link_controller_power), .power_mode(power_mode), .refclk_sel(refclk_sel)
);

// [tb/host_model.sv]
`timescale 1ns/10ps
module host_model
(
    // Clock, reset and bench control
    input wire logic mclk,
    input wire logic rst,
    input wire logic wake_req,
    input wire logic [3:0] lag,
    // Crossed wake-up lines
    input wire logic rts,
    output logic cts
);
    logic rts_ff;
    logic [4:0] wait_ff;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cts <= 1'b1;
            rts_ff <= 1'b0;
            wait_ff <= 5'h0;
        end
        else
        begin
            rts_ff <= rts;
            wait_ff <= (wait_ff != 5'h0) ? wait_ff - 5'h1 : 5'h0;
            if (rts && !rts_ff)
                cts <= 1'b1; // Device sleeps: idle the line, keep watching
            else if (wake_req || wait_ff == 5'h1)
                cts <= 1'b0;
            if (!rts && rts_ff && cts)
                wait_ff <= {1'b0, lag} + 5'h1; // Answer device wake after lag
        end
    end
endmodule

// [tb/uart_transport_wakeup_power_tb_top.sv]
`timescale 1ns/10ps
module uart_transport_wakeup_power_tb_top;
    import wake_pkg::*;
    logic mclk, rst, disable_cmd, tx_pending, tx_buf_empty, confirm_done, confirm_req, tx_allow;
    logic scan_req, host_link_req, remote_link_up, remote_link_down, lp_clk_allowed, cts, rts;
    logic uart_power, link_controller_power, radio_power, wake_req, startup_opt_a, startup_opt_b;
    logic host_cfg_strap_a, host_cfg_strap_b, host_cfg_strap_c, startup_strap_a, startup_strap_b;
    logic environment_strap, startup_strap_a_driven, startup_strap_b_driven, environment_strap_driven;
    logic environment_opt;
    logic [3:0] lag;
    logic [HOST_CFG_W-1:0] host_cfg;
    power_mode_e power_mode;
    refclk_e refclk_sel;
    int fail_count = 0;
    int checked = 0;
    uart_transport_wakeup_power i_dut
    (
        .mclk(mclk), .rst(rst), .disable_cmd(disable_cmd), .tx_pending(tx_pending),
        .tx_buf_empty(tx_buf_empty), .confirm_done(confirm_done), .confirm_req(confirm_req),
        .tx_allow(tx_allow), .scan_req(scan_req), .host_link_req(host_link_req),
        .remote_link_up(remote_link_up), .remote_link_down(remote_link_down),
        .lp_clk_allowed(lp_clk_allowed), .cts(cts), .rts(rts), .uart_power(uart_power),
        .link_controller_power(link_controller_power), .radio_power(radio_power),
        .power_mode(power_mode), .refclk_sel(refclk_sel), .host_cfg_strap_a(host_cfg_strap_a),
        .host_cfg_strap_b(host_cfg_strap_b), .host_cfg_strap_c(host_cfg_strap_c),
        .startup_strap_a(startup_strap_a), .startup_strap_b(startup_strap_b),
        .environment_strap(environment_strap), .startup_strap_a_driven(startup_strap_a_driven),
        .startup_strap_b_driven(startup_strap_b_driven), .environment_strap_driven(environment_strap_driven),
        .host_cfg(host_cfg), .startup_opt_a(startup_opt_a), .startup_opt_b(startup_opt_b),
        .environment_opt(environment_opt)
    );
    host_model i_host (.mclk(mclk), .rst(rst), .wake_req(wake_req), .lag(lag), .rts(rts), .cts(cts));
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        if (fail_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Straps driven opposite to the pull defaults when drv is set
    task automatic boot(input logic [2:0] cfg, input logic drv);
        {host_cfg_strap_c, host_cfg_strap_b, host_cfg_strap_a} = cfg;
        {startup_strap_a, startup_strap_b, environment_strap} = 3'h6;
        {startup_strap_a_driven, startup_strap_b_driven, environment_strap_driven} = {3{drv}};
        rst = 1'b1;
        step(2);
        rst = 1'b0;
        step(2);
        cmp("host_cfg", cfg, host_cfg);
        cmp("opt", {drv, drv, !drv}, {startup_opt_a, startup_opt_b, environment_opt});
        cmp("uart_on", 4'h3, {uart_power, tx_allow});
        cmp("mode", mode_uart_only, power_mode);
        cmp("clock", refclk_main, refclk_sel);
    endtask
    task automatic t_radio();
        scan_req = 1'b1;
        step(2);
        cmp("scan", {1'b1, mode_scan_uart_on}, {radio_power, power_mode});
        host_link_req = 1'b1;
        step(2);
        cmp("link", mode_link_uart_on, power_mode);
        {scan_req, host_link_req} = 2'h0;
        pulse(remote_link_up);
        step(1);
        cmp("remote_up", mode_link_uart_on, power_mode);
        pulse(remote_link_down);
        step(1);
        cmp("remote_down", {1'b0, mode_uart_only}, {link_controller_power, power_mode});
    endtask
    task automatic go_off();
        tx_buf_empty = 1'b0;
        pulse(disable_cmd);
        step(3);
        cmp("drain", 4'h6, {uart_power, tx_allow, confirm_req});
        tx_buf_empty = 1'b1;
        step(2);
        cmp("confirm_off", 4'h5, {uart_power, tx_allow, confirm_req});
        pulse(confirm_done);
        cmp("off", 4'h1, {uart_power, tx_allow, rts});
        cmp("idle", {refclk_none, mode_all_off}, {refclk_sel, power_mode});
        pulse(disable_cmd);
        step(2);
        cmp("no_reenable", 4'h1, {uart_power, rts});
    endtask
    task automatic t_scan_off();
        {scan_req, lp_clk_allowed} = 2'h3;
        step(2);
        cmp("lp_clock", {refclk_low_power, mode_scan_uart_off}, {refclk_sel, power_mode});
        lp_clk_allowed = 1'b0;
        step(2);
        cmp("main_clock", refclk_main, refclk_sel);
        scan_req = 1'b0;
        host_link_req = 1'b1;
        step(1);
        cmp("link_off", {1'b1, refclk_main, mode_link_uart_off}, {radio_power, refclk_sel, power_mode});
        host_link_req = 1'b0;
    endtask
    task automatic t_host_wake();
        pulse(wake_req);
        step(2);
        cmp("host_wake", 4'hA, {uart_power, rts, confirm_req, tx_allow});
        pulse(confirm_done);
        cmp("enabled", 4'h2, {tx_allow, confirm_req});
    endtask
    task automatic t_dev_wake();
        lag = 4'h4;
        tx_pending = 1'b1;
        step(2);
        cmp("dev_wake", 4'h0, {uart_power, rts, tx_allow});
        for (int i = 0; i < 20 && confirm_req !== 1'b1; i++)
            step(1);
        cmp("confirm_on", 4'h6, {uart_power, confirm_req, tx_allow});
        pulse(confirm_done);
        cmp("events", 4'h1, tx_allow);
        tx_pending = 1'b0;
    endtask
    initial
    begin
        {disable_cmd, tx_pending, tx_buf_empty, confirm_done, scan_req, host_link_req} = 6'h0;
        {remote_link_up, remote_link_down, lp_clk_allowed, wake_req, lag} = 8'h0;
        boot(3'h5, 1'b0);
        boot(3'h2, 1'b1);
        t_radio();
        go_off();
        t_scan_off();
        t_host_wake();
        go_off();
        t_dev_wake();
        complete_run();
    end
    initial
    begin
        #100000;
        fail_count++;
        complete_run();
    end
endmodule
